// ---- hw/mcg_pkg.sv ----
// Purpose: Constants and types for the multi-source clock generator.
// Assumes: Avalon-MM register bus, 32-bit data, byte addresses.
// Notes:   Overview of operation follows.
// Overview of operation
// - Source select 00 loop output, 01 internal ref, 10 external ref.
// - Source select 11 reserved, behaves like 00.
// - Ref divider codes 000-011 divide 1,2,4,8; 110,111 divide 64,128.
// - Reference select 1 picks internal reference, 0 external, for loop.
// - Internal ref clock output active only while its enable bit is 1.
// - Stop enable 1 keeps internal ref running in stop if enabled/used.
// - Stop enable 0 turns internal reference off on stop entry.
// - Chosen system clock passes a divide by 1, 2, 4 or 8 divider.
// - Bus divider field 00/01/10/11 gives 1/2/4/8; reset selects 01.
// - Debug clock is always oscillator output divided by 2.
// - Nine operating states: four frequency loop, two phase loop, two low power, stop.
// - No signal leaves the chip; all ports are on-chip.
// - Phase loop lock detector can raise an interrupt request.
// - External reference monitored; failure may request chip reset.
// - Frequency loop reference chosen by reference select.
// - Nine trim bits adjust internal reference frequency.
package mcg_pkg;
  localparam logic [3:0] ADDR_CTRL1  = 4'h0;
  localparam logic [3:0] ADDR_CTRL2  = 4'h4;
  localparam logic [3:0] ADDR_TRIM   = 4'h8;
  localparam logic [3:0] ADDR_STAT   = 4'hC;
  localparam logic [7:0] CTRL1_RST   = 8'h00;
  localparam logic [7:0] CTRL2_RST   = 8'h40;
  localparam logic [7:0] TRIM_RST    = 8'h80;
  localparam logic [1:0] SRC_LOOP    = 2'h0;
  localparam logic [1:0] SRC_INT     = 2'h1;
  localparam logic [1:0] SRC_EXT     = 2'h2;
  localparam int         MON_LIMIT   = 1024;
  localparam int         LOCK_LIMIT  = 16;

  typedef struct packed {
    logic [1:0] source_select;
    logic [2:0] reference_divider;
    logic       reference_select;
    logic       internal_ref_enable;
    logic       internal_ref_stop_enable;
  } mcg_ctrl1_type;

  typedef struct packed {
    logic [1:0] bus_divider;
    logic       lock_irq_enable;
    logic       monitor_reset_enable;
    logic       phase_select;
    logic       low_power;
    logic       fine_trim;
    logic       spare;
  } mcg_ctrl2_type;

  typedef enum logic [3:0] {
    MODE_LOOP_ENGAGED_INTERNAL,
    MODE_LOOP_ENGAGED_EXTERNAL,
    MODE_LOOP_BYPASSED_INTERNAL,
    MODE_LOOP_BYPASSED_EXTERNAL,
    MODE_PHASE_LOOP_ENGAGED_EXTERNAL,
    MODE_PHASE_LOOP_BYPASSED_EXTERNAL,
    MODE_LOW_POWER_BYPASS_INTERNAL,
    MODE_LOW_POWER_BYPASS_EXTERNAL,
    MODE_STOP
  } mcg_mode_type;
endpackage

// ---- hw/mcg_pow2_div.sv ----
// Purpose: Power-of-two clock-enable divider.
// Assumes: Input tick is a one-cycle enable on clk_sys.
// Notes:   Emits one tick per 2**sel input ticks.
`timescale 1ns/1ps
`default_nettype none
module mcg_pow2_div #(
  parameter int SW = 3,
  parameter int CW = 7
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          ce,
  // Divider
  input  wire logic          tick_in,
  input  wire logic [SW-1:0] sel,
  output logic               tick_out
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] mask;

  // Terminal count mask of the selected power
  always_comb begin
    mask = CW'((1 << sel) - 1);
  end

  // Restart whenever the count reaches the mask, so a smaller code
  // written mid-count takes effect without a long wraparound
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_r    <= '0;
      tick_out <= 1'b0;
    end else if (ce) begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if ((cnt_r & mask) == mask) begin
          cnt_r    <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/mcg_core.sv ----
// Purpose: Multi-source clock generator control, as clock enables.
// Assumes: Clocks are modelled as one-cycle ticks synchronous to clk_sys.
// Notes:   Loop analog parts are modelled by the osc/lock ticks at ports.
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module mcg_core
  import mcg_pkg::*;
#(
  parameter int MON_CYCLES = MON_LIMIT
) (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // On-chip clock ticks in
  input  wire logic        int_ref_tick,
  input  wire logic        ext_ref_tick,
  input  wire logic        fll_tick,
  input  wire logic        pll_tick,
  input  wire logic        pll_locked,
  input  wire logic        stop_req,
  // On-chip clock ticks out
  output logic             generator_output_clock,
  output logic             internal_ref_clock_out,
  output logic             ref_div_tick,
  output logic             debug_clock_out,
  output logic             lock_irq,
  output logic             reset_req
);
  mcg_ctrl1_type ctrl1_r;
  mcg_ctrl2_type ctrl2_r;
  logic [7:0]    trim_r;
  logic          lols_r;
  logic          was_locked_r;
  logic          stop_r;
  logic          irc_stop_keep_r;
  logic          rd_ack_r;
  logic          mon_fail_r;
  logic [15:0]   mon_cnt_r;
  logic          bus_tick_r;
  logic [3:0]    bus_cnt_r;
  logic          dco_half_r;
  mcg_mode_type  mode;
  logic [1:0]    src_eff;
  logic          ref_tick;
  logic          int_run;
  logic          osc_tick;
  logic          sel_tick;
  logic [3:0]    bus_mask;
  logic [31:0]   rd_nxt;

  // Writes finish in one cycle; reads wait one cycle for registered data.
  // A frozen block stalls every request so no write is silently lost.
  always_comb begin
    avs_waitrequest = ~ce | (avs_read & ~rd_ack_r);
  end

  // Control registers, lane 0 only holds data
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl1_r <= mcg_ctrl1_type'(CTRL1_RST);
      ctrl2_r <= mcg_ctrl2_type'(CTRL2_RST);
      trim_r  <= TRIM_RST;
    end else if (ce && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        ADDR_CTRL1: ctrl1_r <= mcg_ctrl1_type'(avs_writedata[7:0]);
        ADDR_CTRL2: ctrl2_r <= mcg_ctrl2_type'(avs_writedata[7:0]);
        ADDR_TRIM:  trim_r  <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = 32'h0;
    case (avs_address)
      ADDR_CTRL1: rd_nxt[7:0] = ctrl1_r;
      ADDR_CTRL2: rd_nxt[7:0] = ctrl2_r;
      ADDR_TRIM:  rd_nxt[7:0] = trim_r;
      ADDR_STAT:  rd_nxt[7:0] = {lols_r, pll_locked, mon_fail_r, stop_r,
                                 mode};
      default:    rd_nxt = 32'h0;
    endcase
  end

  // Read data register and acknowledge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_ack_r     <= 1'b0;
      avs_readdata <= 32'h0;
    end else if (ce) begin
      rd_ack_r <= avs_read & ~rd_ack_r;
      if (avs_read && !rd_ack_r) begin
        avs_readdata <= rd_nxt;
      end
    end
  end

  // Reserved code 11 falls back to loop output
  always_comb begin
    src_eff = (ctrl1_r.source_select == 2'h3) ? SRC_LOOP
                                              : ctrl1_r.source_select;
  end

  // Mode decode from current control state
  always_comb begin
    if (stop_r) begin
      mode = MODE_STOP;
    end else begin
      case (src_eff)
        SRC_INT: mode = ctrl2_r.low_power ? MODE_LOW_POWER_BYPASS_INTERNAL
                                          : MODE_LOOP_BYPASSED_INTERNAL;
        SRC_EXT: begin
          if (ctrl2_r.low_power) begin
            mode = MODE_LOW_POWER_BYPASS_EXTERNAL;
          end else if (ctrl2_r.phase_select) begin
            mode = MODE_PHASE_LOOP_BYPASSED_EXTERNAL;
          end else begin
            mode = MODE_LOOP_BYPASSED_EXTERNAL;
          end
        end
        default: begin
          if (ctrl2_r.phase_select) begin
            mode = MODE_PHASE_LOOP_ENGAGED_EXTERNAL;
          end else if (ctrl1_r.reference_select) begin
            mode = MODE_LOOP_ENGAGED_INTERNAL;
          end else begin
            mode = MODE_LOOP_ENGAGED_EXTERNAL;
          end
        end
      endcase
    end
  end

  // Stop entry latches whether the internal reference survives
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stop_r          <= 1'b0;
      irc_stop_keep_r <= 1'b0;
    end else if (ce) begin
      stop_r <= stop_req;
      if (stop_req && !stop_r) begin
        irc_stop_keep_r <= ctrl1_r.internal_ref_stop_enable &
          (ctrl1_r.internal_ref_enable |
           mode == MODE_LOOP_ENGAGED_INTERNAL ||
           mode == MODE_LOOP_BYPASSED_INTERNAL ||
           mode == MODE_LOW_POWER_BYPASS_INTERNAL);
      end
    end
  end

  // Internal reference runs unless stopped without keep
  always_comb begin
    int_run  = !stop_r || irc_stop_keep_r;
    ref_tick = ctrl1_r.reference_select ? (int_ref_tick & int_run)
                                        : ext_ref_tick;
    osc_tick = ctrl2_r.phase_select ? pll_tick : fll_tick;
  end

  // Reference divider, codes map straight to powers of two
  mcg_pow2_div #(
    .SW (3),
    .CW (7)
  ) u_ref_div (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .ce       (ce),
    .tick_in  (ref_tick),
    .sel      (ctrl1_r.reference_divider),
    .tick_out (ref_div_tick)
  );

  // Source mux feeding the bus divider
  always_comb begin
    case (src_eff)
      SRC_INT: sel_tick = int_ref_tick & int_run;
      SRC_EXT: sel_tick = ext_ref_tick;
      default: sel_tick = osc_tick;
    endcase
    if (stop_r) begin
      sel_tick = 1'b0;
    end
    bus_mask = 4'((1 << ctrl2_r.bus_divider) - 1);
  end

  // Bus divider 1/2/4/8
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bus_cnt_r  <= 4'h0;
      bus_tick_r <= 1'b0;
    end else if (ce) begin
      bus_tick_r <= 1'b0;
      if (sel_tick) begin
        if ((bus_cnt_r & bus_mask) == bus_mask) begin
          bus_cnt_r  <= 4'h0;
          bus_tick_r <= 1'b1;
        end else begin
          bus_cnt_r <= bus_cnt_r + 4'h1;
        end
      end
    end
  end

  // Debug clock toggles on every oscillator tick: half rate
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dco_half_r <= 1'b0;
    end else if (ce && osc_tick) begin
      dco_half_r <= ~dco_half_r;
    end
  end

  // Registered clock outputs, all on-chip
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      generator_output_clock <= 1'b0;
      internal_ref_clock_out <= 1'b0;
      debug_clock_out        <= 1'b0;
    end else if (ce) begin
      generator_output_clock <= bus_tick_r;
      internal_ref_clock_out <= int_ref_tick & int_run &
                                ctrl1_r.internal_ref_enable;
      debug_clock_out        <= dco_half_r;
    end
  end

  // Sticky loss of lock; a new loss wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lols_r       <= 1'b0;
      was_locked_r <= 1'b0;
      lock_irq     <= 1'b0;
    end else if (ce) begin
      was_locked_r <= pll_locked;
      if (was_locked_r && !pll_locked) begin
        lols_r <= 1'b1;
      end else if (avs_write && avs_address == ADDR_STAT &&
                   avs_byteenable[0] && avs_writedata[7]) begin
        lols_r <= 1'b0;
      end
      lock_irq <= lols_r & ctrl2_r.lock_irq_enable;
    end
  end

  // External clock monitor: too long without an edge is a failure
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mon_cnt_r  <= 16'h0;
      mon_fail_r <= 1'b0;
      reset_req  <= 1'b0;
    end else if (ce) begin
      if (ext_ref_tick || !ctrl2_r.monitor_reset_enable || stop_r) begin
        mon_cnt_r <= 16'h0;
      end else if (mon_cnt_r == 16'(MON_CYCLES)) begin
        mon_fail_r <= 1'b1;
      end else begin
        mon_cnt_r <= mon_cnt_r + 16'h1;
      end
      reset_req <= mon_fail_r;
    end
  end
endmodule
`default_nettype wire

// ---- tb/msc_props.sv ----
// Purpose: Port-level checks for the clock generator core.
// Assumes: Control bytes are shadowed from accepted bus writes.
// Notes:   Tick outputs are registered, so causes are one cycle back, two for the debug clock.
`timescale 1ns/1ps
`default_nettype none
module msc_props
  import mcg_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        ce,
  // Register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  // Ticks and levels
  input wire logic        int_ref_tick,
  input wire logic        ext_ref_tick,
  input wire logic        fll_tick,
  input wire logic        pll_tick,
  input wire logic        stop_req,
  input wire logic        internal_ref_clock_out,
  input wire logic        ref_div_tick,
  input wire logic        debug_clock_out,
  input wire logic        lock_irq,
  input wire logic        reset_req
);
  logic [7:0] c1_r;
  logic [7:0] c2_r;
  logic       wr_ok;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Shadow only lane-0 writes, the same ones the core accepts
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      c1_r <= CTRL1_RST;
      c2_r <= CTRL2_RST;
    end else if (wr_ok && avs_address == ADDR_CTRL1) begin
      c1_r <= avs_writedata[7:0];
    end else if (wr_ok && avs_address == ADDR_CTRL2) begin
      c2_r <= avs_writedata[7:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_rd_ack;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_write_no_wait: assert property (avs_write && ce |-> !avs_waitrequest)
    else $error("write was stalled");
  a_read_ack: assert property ($rose(avs_read) |-> s_rd_ack)
    else $error("read answer not in second cycle");
  a_irc_tick: assert property (internal_ref_clock_out |-> $past(int_ref_tick))
    else $error("internal ref out without a tick");
  a_irc_gate: assert property (!c1_r[1] |=> !internal_ref_clock_out)
    else $error("internal ref out while disabled");
  a_stop_off: assert property ($rose(stop_req) && !c1_r[0] |->
    ##2 (!internal_ref_clock_out || !stop_req) [*4])
    else $error("internal ref kept in stop");
  a_dbg_tick: assert property ($changed(debug_clock_out) |->
    $past(c2_r[3] ? pll_tick : fll_tick, 2))
    else $error("debug clock moved alone");
  a_ref_src: assert property (ref_div_tick |->
    $past(c1_r[2] ? int_ref_tick : ext_ref_tick))
    else $error("divided ref from wrong source");
  a_lock_gate: assert property (lock_irq |-> $past(c2_r[5]))
    else $error("lock irq while masked");
  a_reset_sticky: assert property (reset_req |=> reset_req)
    else $error("reset request dropped");
endmodule
bind mcg_core msc_props u_props (.clk_sys, .rstn, .ce, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .int_ref_tick, .ext_ref_tick, .fll_tick, .pll_tick, .stop_req,
  .internal_ref_clock_out, .ref_div_tick, .debug_clock_out, .lock_irq,
  .reset_req);
`default_nettype wire

// ---- tb/msc_partner.sv ----
// Purpose: Oscillator ticks feeding the core from the on-chip side.
// Assumes: Each source ticks once per its fixed period of clk_sys.
// Notes:   The external source can be halted to model a dead clock.
`timescale 1ns/1ps
`default_nettype none
module msc_partner #(
  parameter int INT_P = 2,
  parameter int EXT_P = 3,
  parameter int FLL_P = 5,
  parameter int PLL_P = 7
) (
  // Clock, reset, fault control
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic ext_halt,
  // Ticks into the core
  output logic      int_ref_tick,
  output logic      ext_ref_tick,
  output logic      fll_tick,
  output logic      pll_tick
);
  int cnt_r;
  // One counter keeps every source at a fixed phase to the others
  always_ff @(posedge clk_sys) begin
    if (!rstn || cnt_r == 209) cnt_r <= 0;
    else cnt_r <= cnt_r + 1;
  end
  // All sources stay on chip; a halted reference simply stops ticking
  assign int_ref_tick = (cnt_r % INT_P) == 0;
  assign ext_ref_tick = (cnt_r % EXT_P) == 0 && !ext_halt;
  assign fll_tick     = (cnt_r % FLL_P) == 0;
  assign pll_tick     = (cnt_r % PLL_P) == 0;
endmodule
`default_nettype wire

// ---- tb/tb_multi_source_clock_generator.sv ----
// Purpose: Register and tick-rate tests of the clock generator core.
// Assumes: Ticks every 2/3/5/7 cycles for internal/external/frequency loop/phase loop sources.
// Notes:   Monitor window shortened to 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_multi_source_clock_generator;
  import mcg_pkg::*;
  logic        clk_sys, rstn, avs_read, avs_write, stop_req, pll_locked;
  logic        int_ref_tick, ext_ref_tick, fll_tick, pll_tick, ext_halt;
  logic        generator_output_clock, internal_ref_clock_out, ref_div_tick;
  logic        debug_clock_out, lock_irq, reset_req, avs_waitrequest;
  logic        dbg_q;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          n_fail, num_checks, cyc, n;
  int          per[4] = '{5, 2, 3, 5};
  logic [3:0]  ad[4] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_TRIM, 4'h2};
  logic [7:0]  rv[4] = '{CTRL1_RST, CTRL2_RST, TRIM_RST, 8'h00};

  mcg_core #(.MON_CYCLES(16)) DUT (.clk_sys, .rstn, .ce(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .int_ref_tick, .ext_ref_tick, .fll_tick, .pll_tick,
    .pll_locked, .stop_req, .generator_output_clock, .internal_ref_clock_out,
    .ref_div_tick, .debug_clock_out, .lock_irq, .reset_req);
  msc_partner u_far (.clk_sys, .rstn, .ext_halt, .int_ref_tick,
    .ext_ref_tick, .fll_tick, .pll_tick);

  task finish_test();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    // The edge that sees waitrequest low takes the write or the read data
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function logic pick(input int w);
    case (w)
      0: pick = generator_output_clock;
      1: pick = ref_div_tick;
      2: pick = internal_ref_clock_out;
      3: pick = lock_irq;
      4: pick = reset_req;
      default: pick = debug_clock_out & ~dbg_q;
    endcase
  endfunction
  // Previous debug level, so a rise shows for exactly one sample
  always @(posedge clk_sys) begin
    dbg_q <= debug_clock_out;
  end
  // Third gap is used so a divider restarted by a write has settled
  task automatic gap(input int w, output int g);
    int k;
    repeat (3) begin
      k = 0;
      do begin
        @(posedge clk_sys);
        #1;
        k++;
      end while (pick(w) !== 1'b1 && k < 2000);
    end
    g = k;
  endtask
  task automatic tally(input int w, input int len, output int c);
    c = 0;
    repeat (len) begin
      @(posedge clk_sys);
      #1;
      if (pick(w) === 1'b1) c++;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Cut a hang short well past the longest sweep
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {rstn, avs_read, avs_write, stop_req, pll_locked, ext_halt} = 6'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    // Refused writes, then reset values and an unmapped read
    bus(1'b1, ADDR_CTRL1, 8'hFF, 4'hE);
    bus(1'b1, 4'h2, 8'hFF, 4'hF);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ad[i], 8'h00, 4'hF);
      chk("reset value", q, {24'h000000, rv[i]});
    end
    // Every source code against every bus divider code
    for (int s = 0; s < 4; s++) begin
      for (int b = 0; b < 4; b++) begin
        bus(1'b1, ADDR_CTRL1, {s[1:0], 6'h04}, 4'h1);
        bus(1'b1, ADDR_CTRL2, {b[1:0], 6'h00}, 4'h1);
        gap(0, n);
        chk("output gap", n, per[s] << b);
      end
    end
    bus(1'b0, ADDR_CTRL2, 8'h00, 4'hF);
    chk("ctrl2 back", q, 32'h000000C0);
    // Debug clock rises once per two oscillator ticks, either loop
    bus(1'b1, ADDR_CTRL1, 8'h00, 4'h1);
    gap(5, n);
    chk("debug fll", n, 10);
    bus(1'b1, ADDR_CTRL2, 8'h48, 4'h1);
    gap(0, n);
    chk("pll output gap", n, 14);
    gap(5, n);
    chk("debug pll", n, 14);
    bus(1'b0, ADDR_STAT, 8'h00, 4'hF);
    chk("pll mode", q, {28'h0, MODE_PHASE_LOOP_ENGAGED_EXTERNAL});
    // Every reference divider code from both references
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < 2; i++) begin
        bus(1'b1, ADDR_CTRL1, {2'h0, r[2:0], i[0], 2'h0}, 4'h1);
        gap(1, n);
        chk("ref gap", n, (i == 1 ? 2 : 3) << r);
      end
    end
    // Internal reference output, enabled, kept in stop, dropped in stop
    bus(1'b1, ADDR_CTRL1, 8'h03, 4'h1);
    gap(2, n);
    chk("irc gap", n, 2);
    @(posedge clk_sys);
    stop_req <= 1'b1;
    gap(2, n);
    chk("irc in stop", n, 2);
    @(posedge clk_sys);
    stop_req <= 1'b0;
    bus(1'b1, ADDR_CTRL1, 8'h02, 4'h1);
    stop_req <= 1'b1;
    @(posedge clk_sys);
    tally(2, 30, n);
    chk("irc stop off", n, 0);
    @(posedge clk_sys);
    stop_req <= 1'b0;
    bus(1'b1, ADDR_CTRL1, 8'h00, 4'h1);
    tally(2, 30, n);
    chk("irc disabled", n, 0);
    // Lock lost raises the request; masking it drops the request
    bus(1'b1, ADDR_CTRL2, 8'h60, 4'h1);
    pll_locked <= 1'b1;
    repeat (40) @(posedge clk_sys);
    pll_locked <= 1'b0;
    tally(3, 100, n);
    chk("lock irq", n != 0, 1'b1);
    bus(1'b1, ADDR_CTRL2, 8'h40, 4'h1);
    tally(3, 5, n);
    chk("lock masked", lock_irq, 1'b0);
    // Loss of lock is sticky in status until a one is written back
    bus(1'b0, ADDR_STAT, 8'h00, 4'hF);
    chk("lock status", q, {24'h0, 4'h8, MODE_LOOP_ENGAGED_EXTERNAL});
    bus(1'b1, ADDR_STAT, 8'h80, 4'h1);
    bus(1'b0, ADDR_STAT, 8'h00, 4'hF);
    chk("lock cleared", q, {24'h0, 4'h0, MODE_LOOP_ENGAGED_EXTERNAL});
    // Dead external reference asks for a reset that stays asserted
    bus(1'b1, ADDR_CTRL2, 8'h50, 4'h1);
    ext_halt <= 1'b1;
    tally(4, 100, n);
    chk("monitor reset", n != 0, 1'b1);
    @(posedge clk_sys);
    ext_halt <= 1'b0;
    tally(4, 20, n);
    chk("reset sticky", n, 20);
    finish_test();
  end
endmodule
`default_nettype wire
